// ==== include/snv_pkg.sv ====
package snv_pkg;
  localparam int CLK_MHZ      = 25;
  localparam int ENTRY_WIN_MS = 10;
  localparam int ENTRY_CYC    = ENTRY_WIN_MS * 1000 * CLK_MHZ;
  localparam int PROC_US      = 120;
  localparam int PROC_CYC     = PROC_US * CLK_MHZ;
  localparam int COMMIT_MS    = 14;
  localparam int COMMIT_CYC   = COMMIT_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W      = 19;
  localparam int MEAS_W       = 14;
  localparam int RES_LSB      = 10;
  localparam int RES_MSB      = 11;

  localparam logic [6:0]  SLAVE_ADDR    = 7'h44;
  localparam logic [7:0]  CMD_ENTER     = 8'ha0;
  localparam logic [7:0]  CMD_EXIT      = 8'h80;
  localparam logic [7:0]  REG_HUM_RD    = 8'h06;
  localparam logic [7:0]  REG_TEMP_RD   = 8'h11;
  localparam logic [7:0]  REG_ID_HI     = 8'h1e;
  localparam logic [7:0]  REG_ID_LO     = 8'h1f;
  localparam logic [7:0]  REG_HUM_WR    = 8'h46;
  localparam logic [7:0]  REG_TEMP_WR   = 8'h51;
  localparam logic [1:0]  RES_8         = 2'h0;
  localparam logic [1:0]  RES_10        = 2'h1;
  localparam logic [1:0]  RES_12        = 2'h2;
  localparam logic [1:0]  RES_14        = 2'h3;
  localparam logic [15:0] RES_REG_RESET = 16'h0c00;
  localparam logic [1:0]  STAT_VALID    = 2'h0;
  localparam logic [1:0]  STAT_STALE    = 2'h1;
  localparam logic [7:0]  PROG_STAT     = 8'h80;
  localparam logic [7:0]  IDLE_BYTE     = 8'hff;
  // Arbitrary neutral identifier value.
  localparam logic [31:0] ID_DEFAULT    = 32'h5a3c_0f96;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK
  } snv_i2c_state_t;
endpackage : snv_pkg

// ==== include/snv_nvm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface snv_nvm_if;
  logic        rd_req;
  logic        wr_req;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic [1:0]  hum_res;
  logic [1:0]  temp_res;
  modport top (output rd_req, wr_req, addr, wdata,
               input rdata, busy, hum_res, temp_res);
  modport store (input rd_req, wr_req, addr, wdata,
                 output rdata, busy, hum_res, temp_res);
endinterface : snv_nvm_if
`default_nettype wire

// ==== hdl/snv_nvm_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module snv_nvm_store
  import snv_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LOAD_CYC   = TIMER_W'(PROC_CYC),
  parameter logic [TIMER_W-1:0] COMMIT_LEN = TIMER_W'(COMMIT_CYC),
  parameter logic [31:0]        ID_VALUE   = ID_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic erase_n,
  snv_nvm_if.store bus
);
  logic [15:0]        mem_reg [4];
  logic [TIMER_W-1:0] timer_reg;
  logic               wr_pend_reg;
  logic               rd_pend_reg;
  logic [1:0]         idx_reg;
  logic [15:0]        wdata_reg;
  logic [15:0]        rdata_reg;
  logic               rvalid_reg;
  logic               last_tick;

  function automatic logic [1:0] word_idx(input logic [7:0] a);
    case (a)
      REG_HUM_RD, REG_HUM_WR:   word_idx = 2'h0;
      REG_TEMP_RD, REG_TEMP_WR: word_idx = 2'h1;
      REG_ID_HI:                word_idx = 2'h2;
      default:                  word_idx = 2'h3;
    endcase
  endfunction : word_idx

  assign last_tick = timer_reg == TIMER_W'(1);

  // Only erase_n clears the words, so a power cycle on rst_n keeps them.
  always_ff @(posedge clock or negedge erase_n) begin
    if (!erase_n) begin
      mem_reg[0] <= RES_REG_RESET;
      mem_reg[1] <= RES_REG_RESET;
      mem_reg[2] <= ID_VALUE[31:16];
      mem_reg[3] <= ID_VALUE[15:0];
    end else if (wr_pend_reg && last_tick) begin
      mem_reg[idx_reg] <= wdata_reg;
    end
  end

  // The word lands only at the end of the commit time, as a real cell would.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg   <= '0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= 2'h0;
      wdata_reg   <= 16'h0000;
    end else if (timer_reg != '0) begin
      timer_reg <= timer_reg - TIMER_W'(1);
      if (last_tick) begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
      end
    end else if (bus.wr_req) begin
      timer_reg   <= COMMIT_LEN;
      wr_pend_reg <= 1'b1;
      idx_reg     <= word_idx(bus.addr);
      wdata_reg   <= bus.wdata;
    end else if (bus.rd_req) begin
      timer_reg   <= LOAD_CYC;
      rd_pend_reg <= 1'b1;
      idx_reg     <= word_idx(bus.addr);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (bus.rd_req && timer_reg == '0) begin
      rvalid_reg <= 1'b0;
    end else if (rd_pend_reg && last_tick) begin
      rdata_reg  <= mem_reg[idx_reg];
      rvalid_reg <= 1'b1;
    end
  end

  assign bus.busy     = timer_reg != '0;
  assign bus.rdata    = rdata_reg;
  assign bus.hum_res  = mem_reg[0][RES_MSB:RES_LSB];
  assign bus.temp_res = mem_reg[1][RES_MSB:RES_LSB];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_commit_hold: assert property (bus.wr_req && !bus.busy |=> bus.busy [*8])
    else $error("commit time cut short");
  a_load_wait: assert property (bus.rd_req && !bus.busy && !bus.wr_req |=> !rvalid_reg [*8])
    else $error("read data ready too early");
endmodule : snv_nvm_store
`default_nettype wire

// ==== hdl/snv_nvm_access.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Entry accepted only within 10 ms window.
// - Entry is write A0 00 00 to device.
// - Entry takes 120 us before register access.
// - Write 80 00 00 leaves programming mode.
// - All programming registers are 16 bits.
// - Resolution and identifier kept across power cycles.
// - Resolutions read at 06 and 11.
// - Resolutions written at 46 and 51.
// - Resolution field bits 11:10, codes 8-14 bits.
// - Both resolutions default to 14 bits.
// - Register read needs 120 us load time.
// - Register write needs 14 ms commit time.
// - Identifier 32 bits at 1E and 1F.
// - Measurement is four bytes, humidity then temperature.
// - Answer only the configured seven-bit address.
// - Outputs scaled to 14 bits, MSB first.
module snv_nvm_access
  import snv_pkg::*;
#(
  parameter logic [6:0]         DEV_ADDR   = SLAVE_ADDR,
  parameter logic [TIMER_W-1:0] WIN_CYC    = TIMER_W'(ENTRY_CYC),
  parameter logic [TIMER_W-1:0] LOAD_CYC   = TIMER_W'(PROC_CYC),
  parameter logic [TIMER_W-1:0] COMMIT_LEN = TIMER_W'(COMMIT_CYC),
  parameter logic [31:0]        ID_VALUE   = ID_DEFAULT
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              nvm_erase_n,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe,
  input  wire logic [MEAS_W-1:0] hum_sample,
  input  wire logic [MEAS_W-1:0] temp_sample,
  output var  logic              meas_req,
  output var  logic              prog_mode
);
  snv_nvm_if nvm_bus ();

  snv_i2c_state_t     state_reg;
  logic [2:0]         scl_sync_reg, sda_sync_reg;
  logic [TIMER_W-1:0] win_cnt_reg;
  logic [TIMER_W-1:0] entry_cnt_reg;
  logic [3:0]         bit_cnt_reg;
  logic [7:0]         rx_reg;
  logic [7:0]         tx_reg;
  logic               sda_oe_reg, sda_o_reg;
  logic               rw_reg, mack_reg, wtxn_reg;
  logic [2:0]         wr_cnt_reg;
  logic [7:0]         wr_buf_reg [3];
  logic [1:0]         rd_idx_reg;
  logic               prog_reg, meas_req_reg, fresh_reg;
  logic [MEAS_W-1:0]  hum_cap_reg, temp_cap_reg;
  logic               rd_req_reg, wr_req_reg;
  logic [7:0]         addr_reg;
  logic [15:0]        wdata_reg;
  logic [7:0]         tx_byte;
  logic               scl_s, scl_d, sda_s, sda_d;
  logic               scl_rise, scl_fall, bus_start, bus_stop;
  logic               win_open, busy, exec, tail_zero, three;
  logic               enter_ok, exit_ok, rd_ok, wr_ok, mr, fetch_done;

  snv_nvm_store #(
    .LOAD_CYC   (LOAD_CYC),
    .COMMIT_LEN (COMMIT_LEN),
    .ID_VALUE   (ID_VALUE)
  ) u_store (
    .clock   (clock),
    .rst_n   (rst_n),
    .erase_n (nvm_erase_n),
    .bus     (nvm_bus.store)
  );

  // Lower resolutions zero the dropped low bits but keep a 14-bit frame.
  function automatic logic [MEAS_W-1:0] res_mask(input logic [1:0] res);
    case (res)
      RES_8:   res_mask = 14'h3fc0;
      RES_10:  res_mask = 14'h3ff0;
      RES_12:  res_mask = 14'h3ffc;
      default: res_mask = 14'h3fff;
    endcase
  endfunction : res_mask

  function automatic logic is_rd_addr(input logic [7:0] a);
    is_rd_addr = a == REG_HUM_RD || a == REG_TEMP_RD || a == REG_ID_HI || a == REG_ID_LO;
  endfunction : is_rd_addr

  // Bit 2 of the sync shift is only an edge reference behind the second stage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
    end
  end

  assign scl_s     = scl_sync_reg[1];
  assign scl_d     = scl_sync_reg[2];
  assign sda_s     = sda_sync_reg[1];
  assign sda_d     = sda_sync_reg[2];
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_reg <= '0;
    end else if (win_cnt_reg != WIN_CYC) begin
      win_cnt_reg <= win_cnt_reg + TIMER_W'(1);
    end
  end

  assign win_open = win_cnt_reg != WIN_CYC;
  assign busy     = entry_cnt_reg != '0 || nvm_bus.busy;

  assign exec      = bus_stop && wtxn_reg;
  assign three     = wr_cnt_reg == 3'h3;
  assign tail_zero = wr_buf_reg[1] == 8'h00 && wr_buf_reg[2] == 8'h00;
  assign enter_ok  = exec && !prog_reg && three && wr_buf_reg[0] == CMD_ENTER
                     && tail_zero && win_open;
  assign exit_ok   = exec && prog_reg && three && wr_buf_reg[0] == CMD_EXIT
                     && tail_zero;
  assign rd_ok     = exec && prog_reg && three && tail_zero
                     && is_rd_addr(wr_buf_reg[0]);
  assign wr_ok     = exec && prog_reg && three
                     && (wr_buf_reg[0] == REG_HUM_WR || wr_buf_reg[0] == REG_TEMP_WR);
  assign mr        = exec && !prog_reg && wr_cnt_reg == 3'h0;
  assign fetch_done = state_reg == ST_RBYTE && scl_fall && bit_cnt_reg == 4'h8
                      && rd_idx_reg == 2'h0 && !prog_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_reg      <= 1'b0;
      entry_cnt_reg <= '0;
    end else begin
      if (entry_cnt_reg != '0) begin
        entry_cnt_reg <= entry_cnt_reg - TIMER_W'(1);
      end
      if (enter_ok) begin
        prog_reg      <= 1'b1;
        entry_cnt_reg <= LOAD_CYC;
      end else if (exit_ok) begin
        prog_reg <= 1'b0;
      end
    end
  end

  // Requests to the store; the 16-bit word is taken MSB first.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_reg <= 1'b0;
      wr_req_reg <= 1'b0;
      addr_reg   <= 8'h00;
      wdata_reg  <= 16'h0000;
    end else begin
      rd_req_reg <= rd_ok;
      wr_req_reg <= wr_ok;
      if (rd_ok || wr_ok) begin
        addr_reg  <= wr_buf_reg[0];
        wdata_reg <= {wr_buf_reg[1], wr_buf_reg[2]};
      end
    end
  end

  assign nvm_bus.rd_req = rd_req_reg;
  assign nvm_bus.wr_req = wr_req_reg;
  assign nvm_bus.addr   = addr_reg;
  assign nvm_bus.wdata  = wdata_reg;

  // A fresh capture beats a fetch that ends in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meas_req_reg <= 1'b0;
      fresh_reg    <= 1'b0;
      hum_cap_reg  <= '0;
      temp_cap_reg <= '0;
    end else begin
      meas_req_reg <= mr;
      if (mr) begin
        fresh_reg    <= 1'b1;
        hum_cap_reg  <= hum_sample & res_mask(nvm_bus.hum_res);
        temp_cap_reg <= temp_sample & res_mask(nvm_bus.temp_res);
      end else if (fetch_done) begin
        fresh_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    tx_byte = IDLE_BYTE;
    if (prog_reg) begin
      case (rd_idx_reg)
        2'h0:    tx_byte = PROG_STAT | {7'h00, busy};
        2'h1:    tx_byte = nvm_bus.rdata[15:8];
        2'h2:    tx_byte = nvm_bus.rdata[7:0];
        default: tx_byte = IDLE_BYTE;
      endcase
    end else begin
      case (rd_idx_reg)
        2'h0:    tx_byte = {fresh_reg ? STAT_VALID : STAT_STALE, hum_cap_reg[13:8]};
        2'h1:    tx_byte = hum_cap_reg[7:0];
        2'h2:    tx_byte = temp_cap_reg[13:6];
        default: tx_byte = {temp_cap_reg[5:0], 2'b00};
      endcase
    end
  end

  // While the store or the entry step is busy the address is not acknowledged,
  // so a master that ignores the waits sees a NACK instead of corrupting data.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      sda_oe_reg  <= 1'b0;
      rw_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      wtxn_reg    <= 1'b0;
      wr_cnt_reg  <= 3'h0;
      rd_idx_reg  <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        wr_buf_reg[i] <= 8'h00;
      end
    end else if (bus_start) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
      wtxn_reg    <= 1'b0;
      wr_cnt_reg  <= 3'h0;
      rd_idx_reg  <= 2'h0;
    end else if (bus_stop) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      wtxn_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            rx_reg      <= {rx_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (state_reg == ST_WBYTE) begin
              state_reg  <= ST_WACK;
              sda_oe_reg <= 1'b1;
              if (wr_cnt_reg < 3'h3) begin
                wr_buf_reg[wr_cnt_reg[1:0]] <= rx_reg;
              end
              if (wr_cnt_reg != 3'h4) begin
                wr_cnt_reg <= wr_cnt_reg + 3'h1;
              end
            end else if (rx_reg[7:1] == DEV_ADDR && !(prog_reg && busy)) begin
              state_reg  <= ST_AACK;
              sda_oe_reg <= 1'b1;
              rw_reg     <= rx_reg[0];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg  <= ST_RBYTE;
              tx_reg     <= {tx_byte[6:0], 1'b0};
              sda_oe_reg <= !tx_byte[7];
            end else begin
              state_reg  <= ST_WBYTE;
              sda_oe_reg <= 1'b0;
              wtxn_reg   <= 1'b1;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_reg   <= ST_WBYTE;
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
          end
        end
        ST_RBYTE: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg  <= ST_RACK;
              sda_oe_reg <= 1'b0;
              if (rd_idx_reg != 2'h3) begin
                rd_idx_reg <= rd_idx_reg + 2'h1;
              end
            end else begin
              sda_oe_reg <= !tx_reg[7];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_s;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg) begin
              state_reg  <= ST_RBYTE;
              tx_reg     <= {tx_byte[6:0], 1'b0};
              sda_oe_reg <= !tx_byte[7];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // The pin is only ever pulled low; release is the high level.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  assign sda_o     = sda_o_reg;
  assign sda_oe    = sda_oe_reg;
  assign meas_req  = meas_req_reg;
  assign prog_mode = prog_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_addr_match: assert property (state_reg == ST_AACK |-> rx_reg[7:1] == DEV_ADDR)
    else $error("acknowledged a foreign address");
  a_entry_window: assert property ($rose(prog_reg) |-> $past(win_open))
    else $error("programming entered after the window");
  a_entry_code: assert property ($rose(prog_reg) |-> $past(wr_buf_reg[0]) == CMD_ENTER)
    else $error("programming entered without entry code");
  a_entry_wait: assert property ($rose(prog_reg) |-> busy [*8])
    else $error("entry processing time not held");
  a_busy_nack: assert property (state_reg == ST_ADDR && scl_fall && bit_cnt_reg == 4'h8
                                && prog_reg && busy |=> state_reg == ST_IDLE && !sda_oe_reg)
    else $error("address acknowledged while busy");
  a_exit_code: assert property ($fell(prog_reg) |-> $past(wr_buf_reg[0]) == CMD_EXIT
                                && $past(wr_cnt_reg) == 3'h3)
    else $error("programming left without exit code");
  a_meas_scale: assert property (meas_req_reg |-> (hum_cap_reg & ~res_mask(nvm_bus.hum_res))
                                 == 14'h0000)
    else $error("humidity capture not scaled");
  a_fetch_stale: assert property (fetch_done && !mr |=> !fresh_reg)
    else $error("fetched data still marked valid");
  a_read_prog: assert property (rd_req_reg |-> prog_reg && $past(tail_zero))
    else $error("register read outside programming");
endmodule : snv_nvm_access
`default_nettype wire

// ==== testbench/snv_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module snv_i2c_master (
  input  wire logic clock,
  input  wire logic sda_w,
  output var  logic scl,
  output var  logic sda_low
);
  logic [7:0] obs;
  event       obs_ev;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // SDA is released before SCL rises so that this also works as a repeated start.
  task automatic start();
    tick(1);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(1);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask : stop
  // SCL is high for 3 clocks and low for 5. SDA moves one clock after the fall.
  // This keeps four clocks of setup and four of hold around each rise.
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_low = !b;
    tick(4);
    scl = 1'b1;
    tick(2);
    r = sda_w;
    tick(1);
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic a_out, input logic rd);
    logic [7:0] q;
    logic       a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_out, a);
    obs = rd ? q : {7'h00, a};
    ->obs_ev;
  endtask : xfer
endmodule : snv_i2c_master
`default_nettype wire

// ==== testbench/tb_sensor_nvm_programming_access.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_sensor_nvm_programming_access;
  import snv_pkg::*;
  localparam logic [TIMER_W-1:0] T_WIN = TIMER_W'(2000);
  localparam logic [TIMER_W-1:0] T_LD  = TIMER_W'(200);
  localparam logic [TIMER_W-1:0] T_CM  = TIMER_W'(300);
  logic              clock = 1'b0;
  logic              rst_n;
  logic              nvm_erase_n;
  logic [MEAS_W-1:0] hs, ts;
  logic              sda_o, sda_oe, meas_req, prog_mode, scl, m_low, sda_w;
  logic [7:0]        exp_q[$];
  logic [7:0]        e_v;
  logic [15:0]       hw, tw;
  int                fails = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                mreq_n = 0;
  integer            seed = 83998;
  always #20 clock = ~clock;
  // Open-drain wire with a pull-up: low while either party pulls it.
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_low;
  snv_nvm_access #(.WIN_CYC(T_WIN), .LOAD_CYC(T_LD), .COMMIT_LEN(T_CM)) DUT (
    .clock(clock), .rst_n(rst_n), .nvm_erase_n(nvm_erase_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .hum_sample(hs), .temp_sample(ts),
    .meas_req(meas_req), .prog_mode(prog_mode));
  snv_i2c_master m (.clock(clock), .sda_w(sda_w), .scl(scl), .sda_low(m_low));
  always @(m.obs_ev) begin
    e_v = exp_q.pop_front();
    `CHK(m.obs, e_v)
  end
  always @(posedge clock) begin
    if (meas_req === 1'b1) mreq_n++;
    cyc++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Counts: %0d compared, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic do_reset(input logic erase);
    @(negedge clock);
    rst_n = 1'b0;
    nvm_erase_n = !erase;
    m.tick(4);
    rst_n = 1'b1;
    nvm_erase_n = 1'b1;
    m.tick(3);
  endtask : do_reset
  // Address only; a busy or foreign device answers with a NACK.
  task automatic probe(input logic [6:0] a, input logic [7:0] ack);
    m.start();
    exp_q.push_back(ack);
    m.xfer({a, 1'b0}, 1'b1, 1'b0);
    m.stop();
  endtask : probe
  task automatic wr3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] b[3];
    b = '{b0, b1, b2};
    m.start();
    exp_q.push_back(8'h00);
    m.xfer({SLAVE_ADDR, 1'b0}, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back(8'h00);
      m.xfer(b[k], 1'b1, 1'b0);
    end
    m.stop();
  endtask : wr3
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    wr3(a, 8'h00, 8'h00);
    m.tick(int'(T_LD) + 10);
    m.start();
    exp_q.push_back(8'h00);
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, 1'b0);
    exp_q.push_back(PROG_STAT);
    m.xfer(8'hff, 1'b0, 1'b1);
    exp_q.push_back(e[15:8]);
    m.xfer(8'hff, 1'b0, 1'b1);
    exp_q.push_back(e[7:0]);
    m.xfer(8'hff, 1'b1, 1'b1);
    m.stop();
  endtask : rd_reg
  task automatic fetch(input logic [1:0] st, input int n);
    logic [7:0]        e[4];
    logic [MEAS_W-1:0] hm, tm;
    // Each step down in resolution clears two more low bits of the 14-bit frame.
    hm = (hs >> (6 - 2 * hw[RES_MSB:RES_LSB])) << (6 - 2 * hw[RES_MSB:RES_LSB]);
    tm = (ts >> (6 - 2 * tw[RES_MSB:RES_LSB])) << (6 - 2 * tw[RES_MSB:RES_LSB]);
    e = '{{st, hm[13:8]}, hm[7:0], tm[13:6], {tm[5:0], 2'b00}};
    m.start();
    exp_q.push_back(8'h00);
    m.xfer({SLAVE_ADDR, 1'b1}, 1'b1, 1'b0);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(e[k]);
      m.xfer(8'hff, k == n - 1, 1'b1);
    end
    m.stop();
  endtask : fetch
  initial begin
    rst_n = 1'b0;
    nvm_erase_n = 1'b0;
    hs = MEAS_W'($random(seed));
    ts = MEAS_W'($random(seed));
    do_reset(1'b1);
    probe(SLAVE_ADDR ^ 7'h01, 8'h01);
    wr3(CMD_ENTER, 8'h00, 8'h00);
    m.tick(3);
    `CHK(prog_mode, 1'b1)
    probe(SLAVE_ADDR, 8'h01);
    m.tick(int'(T_LD) + 10);
    $display("test entry done");
    hw = RES_REG_RESET;
    tw = RES_REG_RESET;
    for (int i = 0; i < 4; i++) begin
      rd_reg(REG_HUM_RD, hw);
      hw[RES_MSB:RES_LSB] = 2'(i + 2);
      wr3(REG_HUM_WR, hw[15:8], hw[7:0]);
      probe(SLAVE_ADDR, 8'h01);
      m.tick(int'(T_CM) + 10);
      rd_reg(REG_TEMP_RD, tw);
      tw[RES_MSB:RES_LSB] = 2'(5 - i);
      wr3(REG_TEMP_WR, tw[15:8], tw[7:0]);
      m.tick(int'(T_CM) + 10);
      rd_reg(REG_HUM_RD, hw);
      rd_reg(REG_TEMP_RD, tw);
    end
    $display("test resolution done");
    rd_reg(REG_ID_HI, ID_DEFAULT[31:16]);
    rd_reg(REG_ID_LO, ID_DEFAULT[15:0]);
    wr3(CMD_EXIT, 8'h00, 8'h00);
    m.tick(3);
    `CHK(prog_mode, 1'b0)
    hs = MEAS_W'($random(seed));
    ts = MEAS_W'($random(seed));
    probe(SLAVE_ADDR, 8'h00);
    m.tick(3);
    `CHK(mreq_n, 1)
    fetch(STAT_VALID, 4);
    fetch(STAT_STALE, 1);
    $display("test measurement done");
    do_reset(1'b0);
    wr3(CMD_ENTER, 8'h00, 8'h00);
    m.tick(int'(T_LD) + 10);
    rd_reg(REG_HUM_RD, hw);
    rd_reg(REG_TEMP_RD, tw);
    // The loop left 10 and 12 bits; measure once more at 8 and 14 bits.
    hw[RES_MSB:RES_LSB] = RES_8;
    tw[RES_MSB:RES_LSB] = RES_14;
    wr3(REG_HUM_WR, hw[15:8], hw[7:0]);
    m.tick(int'(T_CM) + 10);
    wr3(REG_TEMP_WR, tw[15:8], tw[7:0]);
    m.tick(int'(T_CM) + 10);
    wr3(CMD_EXIT, 8'h00, 8'h00);
    hs = MEAS_W'($random(seed));
    ts = MEAS_W'($random(seed));
    probe(SLAVE_ADDR, 8'h00);
    m.tick(3);
    `CHK(mreq_n, 2)
    fetch(STAT_VALID, 4);
    do_reset(1'b0);
    m.tick(int'(T_WIN) + 50);
    wr3(CMD_ENTER, 8'h00, 8'h00);
    m.tick(3);
    `CHK(prog_mode, 1'b0)
    $display("test retention and window done");
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule : tb_sensor_nvm_programming_access
`default_nettype wire
